// *** verilog/dpc_ctrl.sv ***
`timescale 1ns/1ps
// Contract
// [RL1] Keep own word count and memory address
// [RL2] Burst breaks; odd last word normal break
// [RL3] Double buffer two words before requesting
// [RL4] Grant within 14.8 us else timing error
// [RL5] Host serves lone word within 7.4 us
// [RL6] Host spends 4 us per pair break
// [RL7] Word count two's complement bits 03-17
// [RL8] Overflow set when transfers complete
// [RL9] Function code bits 03-05 control A
// [RL10] Unit number bits 00-02 control A
// [RL11] Execute only while go bit 08 set; code samples go only in idle, clearing it does not stop a transfer
// [RL12] Disable gates done and error interrupts
// [RL13] Disable gates attention interrupt
// [RL14] Summary flag ORs error, attention, done
// [RL15] Done set except idle, recal, seek
// [RL16] Attention is OR of unit lines
// [RL17] Error is OR of all errors; code ORs only timing error and drive unsafe, overflow is not included
// [RL18] Break request when memory cycle needed
// [RL19] Busy whenever function not idle
// [RL20] Drive reports unsafe, drops ready
// [RL21] Advance count and pointer per word
// [RL22] Timing error feeds error, stops transfer
module dpc_ctrl #(
    parameter int PAIR_LAT = dpc_pkg::PAIR_LAT_CYC,
    parameter int SINGLE_LAT = dpc_pkg::SINGLE_LAT_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Drive side
    input wire logic [7:0] unit_attention_lines,
    input wire logic drive_unsafe,
    input wire logic drive_ready,
    input wire logic disk_word_valid,
    input wire logic [17:0] disk_word_in,
    output logic disk_word_take,
    output logic [17:0] disk_word_out,
    output logic [2:0] unit_select,
    // Interrupt request
    output logic irq,
    output logic summary_flag,
    // Data channel
    dpc_chan_if.ctrl ch
);
    logic [17:0] ctrl_q;
    logic [17:0] wc_q;
    logic [16:0] ptr_q;
    logic [17:0] buf_q [2];
    logic [1:0] fill_q;
    logic [1:0] xcnt_q;
    logic done_q, timing_q, ovf_q, lone_q;
    logic [11:0] lat_q;
    dpc_pkg::dpc_state_t state_q;
    dpc_pkg::dpc_func_t func;
    logic go, is_write, data_fn, wr_en, rd_en, attention_summary, error_summary, last_one, word_xfer;
    logic clr_done, clr_err;
    logic [31:0] status;

    // Field decode of control A
    assign func = dpc_pkg::dpc_func_t'(ctrl_q[dpc_pkg::FUNC_LSB +: 3]); // [RL9]
    assign unit_select = ctrl_q[dpc_pkg::UNIT_LSB +: 3]; // [RL10]
    assign go = ctrl_q[dpc_pkg::GO_BIT];
    assign is_write = (func == dpc_pkg::FN_WRITE) || (func == dpc_pkg::FN_WRITE_ALL);
    assign data_fn = (func == dpc_pkg::FN_READ) || (func == dpc_pkg::FN_WRITE) || (func == dpc_pkg::FN_READ_ALL)
        || (func == dpc_pkg::FN_WRITE_ALL) || (func == dpc_pkg::FN_WCHECK);
    // Only one word remains when count is minus one
    assign last_one = (wc_q[dpc_pkg::WC_LSB +: dpc_pkg::WC_W] == 15'h7FFF);
    assign word_xfer = (state_q == dpc_pkg::ST_XFER) && ch.ack;

    // APB: zero-wait slave, every access answered at once
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign clr_done = wr_en && (paddr == dpc_pkg::REG_FLAG_CLR) && pwdata[dpc_pkg::ST_DONE];
    assign clr_err = wr_en && (paddr == dpc_pkg::REG_FLAG_CLR) && pwdata[dpc_pkg::ST_ERROR];

    // Flags and summary
    assign attention_summary = |unit_attention_lines; // [RL16]
    assign error_summary = timing_q || drive_unsafe; // [RL17] [RL22]
    assign summary_flag = error_summary || attention_summary || done_q; // [RL14]
    assign irq = ((done_q || error_summary) && !ctrl_q[dpc_pkg::DED_BIT]) // [RL12]
        || (attention_summary && !ctrl_q[dpc_pkg::ATD_BIT]); // [RL13]

    always_comb begin
        status = 32'h0;
        status[dpc_pkg::ST_SUMMARY] = summary_flag;
        status[dpc_pkg::ST_DONE] = done_q;
        status[dpc_pkg::ST_ATTN] = attention_summary;
        status[dpc_pkg::ST_ERROR] = error_summary;
        status[dpc_pkg::ST_BREAK] = ch.break_request;
        status[dpc_pkg::ST_BUSY] = (func != dpc_pkg::FN_IDLE); // [RL19]
        status[dpc_pkg::ST_OVF] = ovf_q;
        status[dpc_pkg::ST_TIMING] = timing_q;
        status[dpc_pkg::ST_UNSAFE] = drive_unsafe;
        status[dpc_pkg::ST_IRQ] = irq;
    end

    // Read data registered in setup phase, valid during access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (rd_en) begin
            unique case (paddr)
                dpc_pkg::REG_CTRL_A: prdata <= {14'h0, ctrl_q};
                dpc_pkg::REG_WC: prdata <= {14'h0, wc_q[17:3], 3'h0};
                dpc_pkg::REG_PTR: prdata <= {15'h0, ptr_q};
                dpc_pkg::REG_STATUS: prdata <= status;
                default: prdata <= 32'h0;
            endcase
        end
    end

    // Control register A; go clears when function ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= dpc_pkg::CTRL_RESET;
        end else if (wr_en && paddr == dpc_pkg::REG_CTRL_A) begin
            ctrl_q <= pwdata[17:0];
        end else if (state_q == dpc_pkg::ST_DONE_S) begin
            ctrl_q[dpc_pkg::GO_BIT] <= 1'b0;
            ctrl_q[dpc_pkg::FUNC_LSB +: 3] <= 3'h0;
        end
    end

    // Word counter (bits 17:3 hold count) and memory pointer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wc_q <= dpc_pkg::WC_RESET;
            ptr_q <= 17'h0;
        end else if (wr_en && paddr == dpc_pkg::REG_WC) begin
            wc_q <= {pwdata[17:3], 3'h0}; // [RL7]
        end else if (wr_en && paddr == dpc_pkg::REG_PTR) begin
            ptr_q <= pwdata[16:0];
        end else if (word_xfer) begin
            wc_q <= wc_q + 18'h00008; // [RL1] [RL21]
            ptr_q <= ptr_q + 17'h00001;
        end
    end

    // Overflow and done: set wins over software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            if (word_xfer && last_one) begin
                ovf_q <= 1'b1; // [RL8]
            end else if (wr_en && paddr == dpc_pkg::REG_WC) begin
                ovf_q <= 1'b0;
            end
            if (state_q == dpc_pkg::ST_DONE_S && data_fn) begin
                done_q <= 1'b1; // [RL15]
            end else if (clr_done) begin
                done_q <= 1'b0;
            end
        end
    end

    // Double buffer and drive handshake
    assign disk_word_take = (state_q == dpc_pkg::ST_FILL) && disk_word_valid && drive_ready && !drive_unsafe;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_q[0] <= 18'h0;
            buf_q[1] <= 18'h0;
            fill_q <= 2'h0;
            disk_word_out <= 18'h0;
        end else if (disk_word_take) begin
            buf_q[fill_q[0]] <= disk_word_in; // [RL3]
            fill_q <= fill_q + 2'h1;
        end else if (word_xfer) begin
            if (!is_write) buf_q[xcnt_q[0]] <= ch.rdata;
            disk_word_out <= ch.rdata;
        end else if (state_q == dpc_pkg::ST_IDLE) begin
            fill_q <= 2'h0;
        end else if (state_q == dpc_pkg::ST_REQ) begin
            fill_q <= 2'h0;
        end
    end

    // Latency watchdog and timing error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lat_q <= 12'h0;
            timing_q <= 1'b0;
        end else begin
            if (state_q == dpc_pkg::ST_REQ && !ch.grant) begin
                lat_q <= lat_q + 12'h001;
            end else begin
                lat_q <= 12'h0;
            end
            if (state_q == dpc_pkg::ST_REQ && !ch.grant &&
                lat_q >= 12'(ch.burst ? PAIR_LAT - 1 : SINGLE_LAT - 1)) begin
                timing_q <= 1'b1; // [RL4] [RL5]
            end else if (clr_err) begin
                timing_q <= 1'b0;
            end
        end
    end

    // Channel sequencer: fill pair, request, exchange, repeat
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= dpc_pkg::ST_IDLE;
            xcnt_q <= 2'h0;
        end else begin
            unique case (state_q)
                dpc_pkg::ST_IDLE: begin
                    xcnt_q <= 2'h0;
                    if (go && func != dpc_pkg::FN_IDLE) begin // [RL11]
                        state_q <= data_fn ? dpc_pkg::ST_FILL : dpc_pkg::ST_DONE_S;
                    end
                end
                dpc_pkg::ST_FILL: begin
                    if (timing_q || drive_unsafe) begin
                        state_q <= dpc_pkg::ST_DONE_S; // [RL22]
                    end else if (disk_word_take && (fill_q == 2'h1 || last_one)) begin
                        state_q <= dpc_pkg::ST_REQ;
                    end
                end
                dpc_pkg::ST_REQ: begin
                    xcnt_q <= 2'h0;
                    if (timing_q) begin
                        state_q <= dpc_pkg::ST_DONE_S;
                    end else if (ch.grant) begin
                        state_q <= dpc_pkg::ST_XFER;
                    end
                end
                dpc_pkg::ST_XFER: begin
                    if (ch.ack) begin
                        xcnt_q <= xcnt_q + 2'h1;
                        if (last_one) begin
                            state_q <= dpc_pkg::ST_DONE_S;
                        end else if (xcnt_q == 2'h1) begin
                            state_q <= dpc_pkg::ST_FILL;
                        end
                    end
                end
                dpc_pkg::ST_DONE_S: state_q <= dpc_pkg::ST_IDLE;
                default: state_q <= dpc_pkg::ST_IDLE;
            endcase
        end
    end

    // Break mode latched as the buffer closes, so it cannot wobble while the host arbitrates
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lone_q <= 1'b0;
        end else if (state_q == dpc_pkg::ST_FILL && disk_word_take && (fill_q == 2'h1 || last_one)) begin
            lone_q <= (fill_q == 2'h0); // [RL2]
        end
    end

    // Channel outputs; burst unless lone final word
    assign ch.break_request = (state_q == dpc_pkg::ST_REQ) || (state_q == dpc_pkg::ST_XFER); // [RL18]
    assign ch.burst = !lone_q; // [RL2]
    assign ch.write_mem = !is_write;
    assign ch.memory_pointer = ptr_q; // [RL1]
    assign ch.wdata = buf_q[xcnt_q[0]];
endmodule : dpc_ctrl

// *** verilog/dpc_pkg.sv ***
package dpc_pkg;
    // Word and field layout
    localparam int WORD_W = 18;
    localparam int UNIT_LSB = 0;
    localparam int FUNC_LSB = 3;
    localparam int GO_BIT = 8;
    localparam int WC_LSB = 3;
    localparam int WC_W = 15;
    // APB register byte offsets
    localparam logic [7:0] REG_CTRL_A = 8'h00;
    localparam logic [7:0] REG_WC = 8'h04;
    localparam logic [7:0] REG_PTR = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_FLAG_CLR = 8'h10;
    // Status register bit positions
    localparam int ST_SUMMARY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_ATTN = 2;
    localparam int ST_ERROR = 3;
    localparam int ST_BREAK = 4;
    localparam int ST_BUSY = 5;
    localparam int ST_OVF = 6;
    localparam int ST_TIMING = 7;
    localparam int ST_UNSAFE = 8;
    localparam int ST_IRQ = 9;
    // Control register extra bits
    localparam int DED_BIT = 9;
    localparam int ATD_BIT = 10;
    // Reset values
    localparam logic [17:0] CTRL_RESET = 18'h00000;
    localparam logic [17:0] WC_RESET = 18'h00000;
    // Latency windows
    localparam real CLK_NS = 10.0;
    localparam real PAIR_LAT_US = 14.8;
    localparam real SINGLE_LAT_US = 7.4;
    localparam real BREAK_PAIR_US = 4.0;
    localparam int PAIR_LAT_CYC = int'($floor(PAIR_LAT_US * 1000.0 / CLK_NS));
    localparam int SINGLE_LAT_CYC = int'($floor(SINGLE_LAT_US * 1000.0 / CLK_NS));
    localparam int BREAK_PAIR_CYC = int'($floor(BREAK_PAIR_US * 1000.0 / CLK_NS));
    // Function codes
    typedef enum logic [2:0] {
        FN_IDLE = 3'h0, FN_READ = 3'h1, FN_WRITE = 3'h2, FN_RECAL = 3'h3,
        FN_SEEK = 3'h4, FN_READ_ALL = 3'h5, FN_WRITE_ALL = 3'h6, FN_WCHECK = 3'h7
    } dpc_func_t;
    // Channel states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0, ST_FILL = 3'h1, ST_REQ = 3'h2, ST_XFER = 3'h3, ST_DONE_S = 3'h4
    } dpc_state_t;
endpackage : dpc_pkg

// *** verilog/dpc_chan_if.sv ***
`timescale 1ns/1ps
// Single-cycle data channel between controller and host I/O processor
interface dpc_chan_if;
    logic break_request;
    logic burst;
    logic write_mem;
    logic [16:0] memory_pointer;
    logic [17:0] wdata;
    logic grant;
    logic ack;
    logic [17:0] rdata;
    modport ctrl (output break_request, burst, write_mem, memory_pointer, wdata, input grant, ack, rdata);
    modport host (input break_request, burst, write_mem, memory_pointer, wdata, output grant, ack, rdata);
endinterface : dpc_chan_if

// *** verilog/dpc_host.sv ***
`timescale 1ns/1ps
module dpc_host #(
    parameter int GRANT_DELAY = 4
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Memory user side
    output logic mem_we,
    output logic [16:0] mem_addr,
    output logic [17:0] mem_wdata,
    input wire logic [17:0] mem_rdata,
    // Data channel
    dpc_chan_if.host ch
);
    logic [7:0] wait_q;
    logic [7:0] sync_q;
    logic active_q;

    // Grant after a short arbitration delay, then one word per cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_q <= 8'h0;
            active_q <= 1'b0;
        end else if (!ch.break_request) begin
            wait_q <= 8'h0;
            active_q <= 1'b0;
        end else if (!active_q) begin
            wait_q <= wait_q + 8'h01;
            if (wait_q >= 8'(GRANT_DELAY)) active_q <= 1'b1; // [RL5] [RL6]
        end
    end
    assign ch.grant = active_q;

    // Sync interval before words flow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_q <= 8'h0;
        end else if (!active_q) begin
            sync_q <= 8'h0;
        end else if (sync_q != 8'h03) begin
            sync_q <= sync_q + 8'h01;
        end
    end
    // Gated by the request, so no word is acknowledged in the cycle after the break ends
    assign ch.ack = active_q && ch.break_request && (sync_q == 8'h03);

    // Memory access driven from channel
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_we <= 1'b0;
            mem_addr <= 17'h0;
            mem_wdata <= 18'h0;
        end else begin
            mem_we <= ch.ack && ch.write_mem;
            mem_addr <= ch.memory_pointer;
            mem_wdata <= ch.wdata;
        end
    end
    assign ch.rdata = mem_rdata;
endmodule : dpc_host

// *** tb/dpc_chan_sva.sv ***
`timescale 1ns/1ps
module dpc_chan_sva #(
    parameter int PAIR_LAT = 20
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Channel signals
    input wire logic break_request,
    input wire logic burst,
    input wire logic write_mem,
    input wire logic [16:0] memory_pointer,
    input wire logic [17:0] wdata,
    input wire logic grant,
    input wire logic ack
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // A word may only move inside a requested break
    property p_ack_in_break;
        ack |-> break_request;
    endproperty
    a_ack_in_break: assert property (p_ack_in_break) else $error("ack without request");
    // Request stands until a word is moved
    property p_req_hold;
        break_request && !ack |=> break_request;
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped early");
    // Each moved word steps the address by one
    property p_ptr_step;
        ack |=> memory_pointer == $past(memory_pointer) + 17'h00001;
    endproperty
    a_ptr_step: assert property (p_ptr_step) else $error("pointer did not step");
    // Mode, direction and buffered word hold while waiting, so the host sees one coherent request
    property p_qual_stable;
        break_request && !ack |=> $stable({burst, write_mem, wdata});
    endproperty
    a_qual_stable: assert property (p_qual_stable) else $error("request changed while waiting");
    // Host answers inside the latency window
    property p_grant_time;
        $rose(break_request) |-> ##[0:PAIR_LAT] grant;
    endproperty
    a_grant_time: assert property (p_grant_time) else $error("grant too late");
    // A burst break moves two words back to back
    property p_pair_acks;
        $rose(break_request) && burst |-> ##[1:PAIR_LAT] ack ##1 ack;
    endproperty
    a_pair_acks: assert property (p_pair_acks) else $error("burst without two words");
    // A normal break moves at most one word
    property p_lone_ack;
        ack && !burst |=> !ack;
    endproperty
    a_lone_ack: assert property (p_lone_ack) else $error("normal break moved two words");
    // No third word in a burst break
    property p_pair_end;
        ack && burst && $past(ack) |=> !ack;
    endproperty
    a_pair_end: assert property (p_pair_end) else $error("burst moved three words");
endmodule : dpc_chan_sva

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
    // Clock, reset and APB
    logic pclk, presetn, psel, penable, pwrite, pready;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, prdata2, r, r2;
    // Drive side
    logic [7:0] attn_lines;
    logic unsafe, take, irq, sflag, drv_ready, dvalid;
    logic [17:0] dword, dout;
    logic [2:0] usel;
    // Memory side and write log
    logic mem_we;
    logic [16:0] mem_addr;
    logic [17:0] mem_wdata, mem_rdata;
    logic [16:0] wa[$];
    logic [17:0] wd[$];
    int num_errors = 0;
    int checks = 0;
    dpc_chan_if ch();
    dpc_chan_if ch2();
    dpc_ctrl #(.PAIR_LAT(20), .SINGLE_LAT(10)) u_dpc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(), .unit_attention_lines(attn_lines), .drive_unsafe(unsafe), .drive_ready(drv_ready),
        .disk_word_valid(dvalid), .disk_word_in(dword), .disk_word_take(take), .disk_word_out(dout),
        .unit_select(usel), .irq(irq), .summary_flag(sflag), .ch(ch));
    // Second controller faces a host that never grants
    dpc_ctrl #(.PAIR_LAT(20), .SINGLE_LAT(10)) u_dpc_ctrl_2 (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata2), .pready(),
        .pslverr(), .unit_attention_lines(attn_lines), .drive_unsafe(unsafe), .drive_ready(drv_ready),
        .disk_word_valid(dvalid), .disk_word_in(dword), .disk_word_take(), .disk_word_out(),
        .unit_select(), .irq(), .summary_flag(), .ch(ch2));
    dpc_host u_dpc_host (.pclk(pclk), .presetn(presetn), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .ch(ch));
    dpc_chan_sva #(.PAIR_LAT(20)) u_sva (.pclk(pclk), .presetn(presetn), .break_request(ch.break_request),
        .burst(ch.burst), .write_mem(ch.write_mem), .memory_pointer(ch.memory_pointer), .wdata(ch.wdata),
        .grant(ch.grant), .ack(ch.ack));
    // Memory content is a function of address; faulty host never answers
    // Memory answers for the address the channel presents in the acknowledge cycle
    assign mem_rdata = {1'b0, ch.memory_pointer} ^ 18'h15555;
    assign ch2.grant = 1'b0;
    assign ch2.ack = 1'b0;
    assign ch2.rdata = 18'h00000;
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Drive offers the next word once one is taken; memory writes are logged
    always @(posedge pclk) begin
        if (take === 1'b1) dword <= dword + 18'h00001;
        if (mem_we === 1'b1) begin
            wa.push_back(mem_addr);
            wd.push_back(mem_wdata);
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer; an idle cycle follows so transfers never collide
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        r = prdata;
        r2 = prdata2;
        if (n >= 100) begin
            num_errors++;
            tally_and_finish();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic st();
        apb(1'b0, dpc_pkg::REG_STATUS, 32'h0);
    endtask : st
    // Poll a status bit of either controller under a bound
    task automatic wait_st(input logic second, input int b);
        int n;
        n = 0;
        do begin
            st();
            n++;
        end while ((second ? r2[b] : r[b]) !== 1'b1 && n < 100);
        if (n >= 100) begin
            num_errors++;
            tally_and_finish();
        end
    endtask : wait_st
    task automatic t_reset();
        apb(1'b0, dpc_pkg::REG_CTRL_A, 32'h0);
        chk(r, {14'h0, dpc_pkg::CTRL_RESET});
        apb(1'b0, dpc_pkg::REG_WC, 32'h0);
        chk(r, {14'h0, dpc_pkg::WC_RESET});
        st();
        chk(r, 32'h0);
        apb(1'b0, 8'h3C, 32'h0);
        chk(r, 32'h0);
        $display("reset test done");
    endtask : t_reset
    task automatic t_fields();
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, dpc_pkg::REG_CTRL_A, 32'(i * 8 + 7 - i));
            apb(1'b0, dpc_pkg::REG_CTRL_A, 32'h0);
            chk(r, 32'(i * 8 + 7 - i));
            chk({29'h0, usel}, 32'(7 - i));
        end
        $display("fields test done");
    endtask : t_fields
    task automatic t_no_done();
        int c[3] = '{0, 3, 4};
        foreach (c[i]) begin
            apb(1'b1, dpc_pkg::REG_CTRL_A, 32'h100 | 32'(c[i] * 8));
            repeat (30) @(posedge pclk);
            st();
            chk({31'h0, r[dpc_pkg::ST_DONE]}, 32'h0);
            apb(1'b1, dpc_pkg::REG_CTRL_A, 32'h0);
        end
        $display("no done test done");
    endtask : t_no_done
    task automatic t_read_odd();
        apb(1'b1, dpc_pkg::REG_PTR, 32'h200);
        apb(1'b1, dpc_pkg::REG_WC, 32'h3FFE8);
        dvalid <= 1'b0;
        apb(1'b1, dpc_pkg::REG_CTRL_A, 32'h10D);
        st();
        chk({31'h0, r[dpc_pkg::ST_BUSY]}, 32'h1);
        chk({31'h0, take}, 32'h0);
        dvalid <= 1'b1;
        drv_ready <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({31'h0, take}, 32'h0);
        drv_ready <= 1'b1;
        wait_st(1'b0, dpc_pkg::ST_DONE);
        chk(32'(wa.size()), 32'h3);
        foreach (wa[i]) begin
            chk({15'h0, wa[i]}, 32'h200 + 32'(i));
            chk({14'h0, wd[i]}, 32'h2A000 + 32'(i));
        end
        apb(1'b0, dpc_pkg::REG_PTR, 32'h0);
        chk(r, 32'h203);
        apb(1'b0, dpc_pkg::REG_WC, 32'h0);
        chk(r, 32'h0);
        st();
        chk(r, 32'h243);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, dpc_pkg::REG_CTRL_A, 32'h200);
        chk({31'h0, irq}, 32'h0);
        // Faulty host side: no grant within the window
        wait_st(1'b1, dpc_pkg::ST_TIMING);
        chk(r2 & 32'h9, 32'h9);
        chk({31'h0, ch2.break_request}, 32'h0);
        apb(1'b0, dpc_pkg::REG_PTR, 32'h0);
        chk(r2, 32'h200);
        apb(1'b1, dpc_pkg::REG_FLAG_CLR, 32'hA);
        st();
        chk(r, 32'h40);
        $display("read test done");
    endtask : t_read_odd
    task automatic t_write_even();
        wa.delete();
        wd.delete();
        apb(1'b1, dpc_pkg::REG_PTR, 32'h300);
        apb(1'b1, dpc_pkg::REG_WC, 32'h3FFF0);
        apb(1'b1, dpc_pkg::REG_CTRL_A, 32'h110);
        wait_st(1'b0, dpc_pkg::ST_DONE);
        chk(32'(wa.size()), 32'h0);
        chk({14'h0, dout}, 32'({1'b0, 17'h00301} ^ 18'h15555));
        apb(1'b0, dpc_pkg::REG_PTR, 32'h0);
        chk(r, 32'h302);
        apb(1'b1, dpc_pkg::REG_FLAG_CLR, 32'hA);
        $display("write test done");
    endtask : t_write_even
    task automatic t_attn_unsafe();
        attn_lines <= 8'h40;
        @(posedge pclk);
        st();
        chk(r & 32'h205, 32'h205);
        apb(1'b1, dpc_pkg::REG_CTRL_A, 32'h400);
        chk({30'h0, irq, sflag}, 32'h1);
        attn_lines <= 8'h00;
        unsafe <= 1'b1;
        @(posedge pclk);
        st();
        chk(r & 32'h109, 32'h109);
        unsafe <= 1'b0;
        $display("attention and unsafe test done");
    endtask : t_attn_unsafe
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        attn_lines = 8'h00;
        unsafe = 1'b0;
        drv_ready = 1'b1;
        dvalid = 1'b1;
        dword = 18'h2A000;
        presetn = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_fields();
        t_no_done();
        t_read_odd();
        t_write_even();
        t_attn_unsafe();
        tally_and_finish();
    end
endmodule : tb
